// ### twac_defines.vh
// Register map, field positions and reset values of the two-wire client address match block
// What this block does
// - An address match sets the address-or-stop flag and its indicator bit to one.
// - Client address bits seven to one form the primary seven-bit client address.
// - Client address bit zero enables answering the all-zero general call address.
// - Data register reads return the byte only during clock hold; writes load it only during a transmit clock hold.
// - In smart mode a data read during a clock hold other than a transmit clock hold starts the selected acknowledge action.
// - Mask mode select zero: each set mask bit makes that address bit always match.
// - Mask mode select one: the mask bits form a second full client address.
// - Mask register holds mask or second address in bits seven to one, select in zero.
// - Any read, or any write with byte lane zero selected, of the data register clears the data interrupt flag.
// - Address or data interrupt holds the clock low until that interrupt is cleared.
// - With the flag set, the indicator reads one for address, zero for stop.
`ifndef TWAC_DEFINES_VH
`define TWAC_DEFINES_VH

// ***********************************
// Register indexes, byte address is four times
// ***********************************
`define TWAC_IDX_CTRL     6'h09
`define TWAC_IDX_STATUS   6'h0B
`define TWAC_IDX_ADDR     6'h0C
`define TWAC_IDX_DATA     6'h0D
`define TWAC_IDX_MASK     6'h0E
`define TWAC_IDX_IRQ_STAT 6'h10
`define TWAC_IDX_IRQ_MASK 6'h11

// ***********************************
// Control register fields
// ***********************************
`define TWAC_CTRL_SMART_MODE_ENABLE   0
`define TWAC_CTRL_ACKNOWLEDGE_ACTION 1
`define TWAC_CTRL_CMD_LO 2
`define TWAC_CTRL_CMD_HI 3
`define TWAC_CMD_NONE     2'h0
`define TWAC_CMD_COMPLETE 2'h2
`define TWAC_CMD_RESPONSE 2'h3

// ***********************************
// Status register fields
// ***********************************
`define TWAC_ST_DIF   7
`define TWAC_ST_ADDRESS_OR_STOP_FLAG  6
`define TWAC_ST_HOLD  5
`define TWAC_ST_RXACK 4
`define TWAC_ST_DIR   1
`define TWAC_ST_AP    0

// ***********************************
// Interrupt status bits
// ***********************************
`define TWAC_IRQ_ADDR 0
`define TWAC_IRQ_STOP 1
`define TWAC_IRQ_DATA 2

`define TWAC_RESET_BYTE 8'h00
`define TWAC_BIT_COUNT  4'h8
`define TWAC_GCALL_ADDR 7'h00

`endif

// ### twac_addr_match.v
// Client address comparator: primary address, general call, mask or second address
`timescale 1ns/1ps
`include "twac_defines.vh"

module twac_addr_match (
  input  wire [6:0] rx_addr,
  input  wire [7:0] client_address,
  input  wire [7:0] client_address_mask,
  output wire       match
);

  wire [6:0] primary;
  wire [6:0] mask_or_second_address;
  wire       mask_mode_select;
  wire       hit_primary;
  wire       hit_second;
  wire       hit_gcall;

  assign primary                = client_address[7:1];
  assign mask_or_second_address = client_address_mask[7:1];
  assign mask_mode_select       = client_address_mask[0];

  // Masked bits always compare equal when the mask field is a mask
  assign hit_primary = (((rx_addr ^ primary) &
                         ~(mask_mode_select ? 7'h00 : mask_or_second_address)) == 7'h00);
  assign hit_second  = mask_mode_select && (rx_addr == mask_or_second_address);
  assign hit_gcall   = client_address[0] && (rx_addr == `TWAC_GCALL_ADDR);

  assign match = hit_primary | hit_second | hit_gcall;

endmodule

// ### twac_client.v
// Two-wire client with address match, clock hold and Wishbone register access
`timescale 1ns/1ps
`include "twac_defines.vh"

module twac_client (
  input  wire        CLOCK,
  input  wire        ARST_N,
  input  wire        WB_CYC_I,
  input  wire        WB_STB_I,
  input  wire        WB_WE_I,
  input  wire [7:0]  WB_ADR_I,
  input  wire [3:0]  WB_SEL_I,
  input  wire [31:0] WB_DAT_I,
  output wire [31:0] WB_DAT_O,
  output wire        WB_ACK_O,
  input  wire        SCL_I,
  output wire        SCL_O,
  output wire        SCL_OE,
  input  wire        SDA_I,
  output wire        SDA_O,
  output wire        SDA_OE,
  output wire        IRQ
);

  // ***********************************
  // Link states
  // ***********************************
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_RXB  = 3'h1;
  localparam [2:0] ST_HOLD = 3'h2;
  localparam [2:0] ST_ACK  = 3'h3;
  localparam [2:0] ST_TXB  = 3'h4;
  localparam [2:0] ST_RACK = 3'h5;
  localparam [2:0] ST_WAIT = 3'h6;

  // ***********************************
  // Pin synchronisers and bus events
  // ***********************************
  reg [1:0] scl_sync_ff;
  reg [1:0] sda_sync_ff;
  reg       scl_d_ff;
  reg       sda_d_ff;

  always @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      scl_sync_ff <= 2'h3;
      sda_sync_ff <= 2'h3;
      scl_d_ff    <= 1'b1;
      sda_d_ff    <= 1'b1;
    end else begin
      scl_sync_ff <= {scl_sync_ff[0], SCL_I};
      sda_sync_ff <= {sda_sync_ff[0], SDA_I};
      scl_d_ff    <= scl_sync_ff[1];
      sda_d_ff    <= sda_sync_ff[1];
    end
  end

  wire scl_s    = scl_sync_ff[1];
  wire sda_s    = sda_sync_ff[1];
  wire scl_rise = scl_s & ~scl_d_ff;
  wire scl_fall = ~scl_s & scl_d_ff;
  // Start and stop only count while the clock line is steady high
  wire start_ev = scl_s & scl_d_ff & ~sda_s & sda_d_ff;
  wire stop_ev  = scl_s & scl_d_ff & sda_s & ~sda_d_ff;

  // ***********************************
  // Registers
  // ***********************************
  reg  [7:0] client_address_ff;
  reg  [7:0] client_address_mask_ff;
  reg  [7:0] client_data_ff;
  reg        smart_mode_enable_ff;
  reg        acknowledge_action_ff;
  reg        data_interrupt_flag_ff;
  reg        address_or_stop_flag_ff;
  reg        address_or_stop_indicator_ff;
  reg        dir_ff;
  reg        rxack_ff;
  reg  [2:0] irq_stat_ff;
  reg  [2:0] irq_mask_ff;
  reg        ack_ff;
  reg  [31:0] rdata_ff;

  reg  [2:0] state_ff;
  reg  [3:0] cnt_ff;
  reg  [7:0] shift_ff;
  reg        addr_phase_ff;
  reg        addressed_ff;
  reg        tx_hold_ff;
  reg        ack_bit_ff;
  reg        done_after_ack_ff;
  reg        sda_drive_ff;

  wire       match;

  twac_addr_match u_match (
    .rx_addr             (shift_ff[7:1]),
    .client_address      (client_address_ff),
    .client_address_mask (client_address_mask_ff),
    .match               (match)
  );

  // ***********************************
  // Wishbone decode
  // ***********************************
  wire       req      = WB_CYC_I & WB_STB_I & ~ack_ff;
  wire [5:0] idx      = WB_ADR_I[7:2];
  wire       wr       = req & WB_WE_I & WB_SEL_I[0];
  wire       rd       = req & ~WB_WE_I;
  wire       hold     = (state_ff == ST_HOLD);
  wire       data_acc = (wr | rd) & (idx == `TWAC_IDX_DATA);
  wire       data_rd  = rd & (idx == `TWAC_IDX_DATA);
  wire       data_wr  = wr & (idx == `TWAC_IDX_DATA);
  wire       ctrl_wr  = wr & (idx == `TWAC_IDX_CTRL);
  wire [1:0] cmd      = WB_DAT_I[`TWAC_CTRL_CMD_HI:`TWAC_CTRL_CMD_LO];
  wire       cmd_ev   = ctrl_wr & (cmd != `TWAC_CMD_NONE);
  wire       acknowledge_action_w = ctrl_wr ? WB_DAT_I[`TWAC_CTRL_ACKNOWLEDGE_ACTION] : acknowledge_action_ff;
  // Release of the held clock is the moment the pending interrupt is cleared
  wire       resume   = hold & (data_acc | cmd_ev);
  wire       complete = cmd_ev & (cmd == `TWAC_CMD_COMPLETE);
  wire       smart    = data_rd & smart_mode_enable_ff;

  // ***********************************
  // Link engine
  // ***********************************
  reg        set_address_or_stop_flag;
  reg        set_ap;
  reg        set_dif;
  reg [2:0]  nxt_state;

  always @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_ff          <= ST_IDLE;
      cnt_ff            <= 4'h0;
      shift_ff          <= `TWAC_RESET_BYTE;
      addr_phase_ff     <= 1'b0;
      addressed_ff      <= 1'b0;
      tx_hold_ff        <= 1'b0;
      ack_bit_ff        <= 1'b0;
      done_after_ack_ff <= 1'b0;
      sda_drive_ff      <= 1'b0;
      dir_ff            <= 1'b0;
      rxack_ff          <= 1'b0;
      client_data_ff    <= `TWAC_RESET_BYTE;
    end else begin
      if (data_wr && hold && tx_hold_ff) begin
        client_data_ff <= WB_DAT_I[7:0];
      end
      if (start_ev) begin
        state_ff      <= ST_RXB;
        cnt_ff        <= 4'h0;
        addr_phase_ff <= 1'b1;
        addressed_ff  <= 1'b0;
        sda_drive_ff  <= 1'b0;
      end else if (stop_ev) begin
        state_ff     <= ST_IDLE;
        addressed_ff <= 1'b0;
        sda_drive_ff <= 1'b0;
      end else begin
        state_ff <= nxt_state;
        case (state_ff)
          ST_RXB: begin
            if (scl_rise) begin
              shift_ff <= {shift_ff[6:0], sda_s};
              cnt_ff   <= cnt_ff + 4'h1;
            end else if (scl_fall && cnt_ff == `TWAC_BIT_COUNT) begin
              cnt_ff <= 4'h0;
              if (addr_phase_ff) begin
                addr_phase_ff <= 1'b0;
                dir_ff        <= match ? shift_ff[0] : dir_ff;
                addressed_ff  <= match;
                tx_hold_ff    <= 1'b0;
              end else begin
                client_data_ff <= shift_ff;
              end
            end
          end
          ST_HOLD: begin
            if (resume) begin
              // A plain clear without smart read or command answers with ACK
              ack_bit_ff        <= (smart | cmd_ev) ? acknowledge_action_w : 1'b0;
              done_after_ack_ff <= complete | ((smart | cmd_ev) & acknowledge_action_w);
              sda_drive_ff      <= ~tx_hold_ff & ~((smart | cmd_ev) & acknowledge_action_w);
              shift_ff          <= data_wr ? WB_DAT_I[7:0] : client_data_ff;
              cnt_ff            <= 4'h0;
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              sda_drive_ff <= 1'b0;
              tx_hold_ff   <= dir_ff;
            end
          end
          ST_TXB: begin
            sda_drive_ff <= ~shift_ff[7];
            if (scl_fall) begin
              shift_ff <= {shift_ff[6:0], 1'b1};
              cnt_ff   <= cnt_ff + 4'h1;
              if (cnt_ff == `TWAC_BIT_COUNT - 4'h1) begin
                sda_drive_ff <= 1'b0;
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              rxack_ff <= sda_s;
            end
            if (scl_fall) begin
              tx_hold_ff <= 1'b1;
            end
          end
          default: begin
            cnt_ff <= 4'h0;
          end
        endcase
      end
    end
  end

  always @* begin
    nxt_state = state_ff;
    set_address_or_stop_flag  = 1'b0;
    set_ap    = 1'b0;
    set_dif   = 1'b0;
    case (state_ff)
      ST_RXB: begin
        if (scl_fall && cnt_ff == `TWAC_BIT_COUNT) begin
          if (!addr_phase_ff) begin
            set_dif   = 1'b1;
            nxt_state = ST_HOLD;
          end else if (match) begin
            set_address_or_stop_flag  = 1'b1;
            set_ap    = 1'b1;
            nxt_state = ST_HOLD;
          end else begin
            nxt_state = ST_WAIT;
          end
        end
      end
      ST_HOLD: begin
        if (resume) begin
          if (complete && tx_hold_ff) begin
            nxt_state = ST_WAIT;
          end else if (tx_hold_ff) begin
            nxt_state = ST_TXB;
          end else begin
            nxt_state = ST_ACK;
          end
        end
      end
      ST_ACK: begin
        if (scl_fall) begin
          if (done_after_ack_ff) begin
            nxt_state = ST_WAIT;
          end else if (dir_ff) begin
            set_dif   = 1'b1;
            nxt_state = ST_HOLD;
          end else begin
            nxt_state = ST_RXB;
          end
        end
      end
      ST_TXB: begin
        if (scl_fall && cnt_ff == `TWAC_BIT_COUNT - 4'h1) begin
          nxt_state = ST_RACK;
        end
      end
      ST_RACK: begin
        if (scl_fall) begin
          set_dif   = 1'b1;
          nxt_state = ST_HOLD;
        end
      end
      ST_IDLE: begin
        nxt_state = ST_IDLE;
      end
      ST_WAIT: begin
        nxt_state = ST_WAIT;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  wire stop_flag = stop_ev & addressed_ff;

  // ***********************************
  // Flags, set wins over clear
  // ***********************************
  always @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      data_interrupt_flag_ff       <= 1'b0;
      address_or_stop_flag_ff      <= 1'b0;
      address_or_stop_indicator_ff <= 1'b0;
      irq_stat_ff                  <= 3'h0;
    end else begin
      data_interrupt_flag_ff  <= set_dif | (data_interrupt_flag_ff & ~(data_acc | cmd_ev));
      address_or_stop_flag_ff <= set_address_or_stop_flag | stop_flag |
                                 (address_or_stop_flag_ff & ~(data_acc | cmd_ev));
      if (set_address_or_stop_flag | stop_flag) begin
        address_or_stop_indicator_ff <= set_ap;
      end
      irq_stat_ff[`TWAC_IRQ_ADDR] <= set_address_or_stop_flag |
                                     (irq_stat_ff[`TWAC_IRQ_ADDR] & ~(rd & idx == `TWAC_IDX_IRQ_STAT));
      irq_stat_ff[`TWAC_IRQ_STOP] <= stop_flag |
                                     (irq_stat_ff[`TWAC_IRQ_STOP] & ~(rd & idx == `TWAC_IDX_IRQ_STAT));
      irq_stat_ff[`TWAC_IRQ_DATA] <= set_dif |
                                     (irq_stat_ff[`TWAC_IRQ_DATA] & ~(rd & idx == `TWAC_IDX_IRQ_STAT));
    end
  end

  // ***********************************
  // Software registers and read mux
  // ***********************************
  wire [7:0] status = {data_interrupt_flag_ff, address_or_stop_flag_ff, hold, rxack_ff,
                       2'b00, dir_ff, address_or_stop_indicator_ff};

  always @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      client_address_ff      <= `TWAC_RESET_BYTE;
      client_address_mask_ff <= `TWAC_RESET_BYTE;
      smart_mode_enable_ff   <= 1'b0;
      acknowledge_action_ff  <= 1'b0;
      irq_mask_ff            <= 3'h0;
      ack_ff                 <= 1'b0;
      rdata_ff               <= 32'h0000_0000;
    end else begin
      ack_ff <= req;
      if (wr && idx == `TWAC_IDX_ADDR) begin
        client_address_ff <= WB_DAT_I[7:0];
      end
      if (wr && idx == `TWAC_IDX_MASK) begin
        client_address_mask_ff <= WB_DAT_I[7:0];
      end
      if (ctrl_wr) begin
        smart_mode_enable_ff  <= WB_DAT_I[`TWAC_CTRL_SMART_MODE_ENABLE];
        acknowledge_action_ff <= WB_DAT_I[`TWAC_CTRL_ACKNOWLEDGE_ACTION];
      end
      if (wr && idx == `TWAC_IDX_IRQ_MASK) begin
        irq_mask_ff <= WB_DAT_I[2:0];
      end
      if (rd) begin
        case (idx)
          `TWAC_IDX_CTRL:     rdata_ff <= {30'h0, acknowledge_action_ff, smart_mode_enable_ff};
          `TWAC_IDX_STATUS:   rdata_ff <= {24'h0, status};
          `TWAC_IDX_ADDR:     rdata_ff <= {24'h0, client_address_ff};
          // Outside clock hold the byte is not valid, so read zero
          `TWAC_IDX_DATA:     rdata_ff <= {24'h0, hold ? client_data_ff : 8'h00};
          `TWAC_IDX_MASK:     rdata_ff <= {24'h0, client_address_mask_ff};
          `TWAC_IDX_IRQ_STAT: rdata_ff <= {29'h0, irq_stat_ff};
          `TWAC_IDX_IRQ_MASK: rdata_ff <= {29'h0, irq_mask_ff};
          default:            rdata_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ***********************************
  // Outputs
  // ***********************************
  assign WB_ACK_O = ack_ff;
  assign WB_DAT_O = rdata_ff;
  assign SCL_O    = 1'b0;
  assign SCL_OE   = hold;
  assign SDA_O    = 1'b0;
  assign SDA_OE   = sda_drive_ff;
  assign IRQ      = |(irq_stat_ff & irq_mask_ff);

endmodule

// ### twac_client_chk.sv
// Concurrent checks on the client's register bus, interrupt and clock hold ports
`timescale 1ns/1ps
`include "twac_defines.vh"

module twac_client_chk (
  input wire        CLOCK,
  input wire        ARST_N,
  input wire        WB_CYC_I,
  input wire        WB_STB_I,
  input wire        WB_WE_I,
  input wire [7:0]  WB_ADR_I,
  input wire [3:0]  WB_SEL_I,
  input wire [31:0] WB_DAT_I,
  input wire [31:0] WB_DAT_O,
  input wire        WB_ACK_O,
  input wire        SCL_OE,
  input wire        SDA_OE,
  input wire        IRQ
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!ARST_N);

  // ***********************************
  // Helper logic
  // ***********************************
  logic [5:0] idx;
  logic       take;
  logic       mapped;
  logic [2:0] irq_mask_ff;

  assign idx    = WB_ADR_I[7:2];
  assign take   = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  assign mapped = idx inside {`TWAC_IDX_CTRL, `TWAC_IDX_STATUS, `TWAC_IDX_ADDR, `TWAC_IDX_DATA,
                              `TWAC_IDX_MASK, `TWAC_IDX_IRQ_STAT, `TWAC_IDX_IRQ_MASK};

  // Shadow of the interrupt mask, since the checker only sees the ports
  always @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      irq_mask_ff <= 3'h0;
    end else if (take && WB_WE_I && WB_SEL_I[0] && idx == `TWAC_IDX_IRQ_MASK) begin
      irq_mask_ff <= WB_DAT_I[2:0];
    end
  end

  // ***********************************
  // Assertions
  // ***********************************
  chk_ack_answer: assert property (take |=> WB_ACK_O) else $error("ack missing after request");
  chk_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack longer than one cycle");
  chk_unmapped_zero: assert property (take && !WB_WE_I && !mapped |=> WB_DAT_O == 32'h0)
    else $error("unmapped read not zero");
  chk_read_nohold: assert property (take && !WB_WE_I && idx == `TWAC_IDX_DATA && !SCL_OE
    |=> WB_DAT_O[7:0] == 8'h00) else $error("data read outside hold not zero");
  // A write without the low byte lane is no access to the data byte
  chk_data_release: assert property (take && idx == `TWAC_IDX_DATA && (!WB_WE_I || WB_SEL_I[0]) && SCL_OE
    |=> !SCL_OE) else $error("data access did not release clock");
  chk_hold_stands: assert property (SCL_OE && !(take && (idx == `TWAC_IDX_DATA ||
    (idx == `TWAC_IDX_CTRL && WB_WE_I))) |=> SCL_OE) else $error("clock hold dropped early");
  chk_irq_masked: assert property (irq_mask_ff == 3'h0 && $past(irq_mask_ff) == 3'h0 |-> !IRQ)
    else $error("interrupt raised while masked");
  chk_hold_irq: assert property ($rose(SCL_OE) && irq_mask_ff == 3'h7 |-> ##[0:2] IRQ)
    else $error("hold without interrupt");

  cover property ($rose(SCL_OE));
  cover property ($rose(SDA_OE));
  cover property (IRQ && SCL_OE);
endmodule

bind twac_client twac_client_chk twac_client_chk_inst (
  .CLOCK(CLOCK), .ARST_N(ARST_N), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
  .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O),
  .WB_ACK_O(WB_ACK_O), .SCL_OE(SCL_OE), .SDA_OE(SDA_OE), .IRQ(IRQ));

// ### twac_i2c_host.sv
// Behavioural two-wire bus host driving the far side of the client
`timescale 1ns/1ps

module twac_i2c_host (
  input  wire        scl_line,
  input  wire        sda_line,
  output logic       scl_low,
  output logic       sda_low
);
  logic [7:0] stuck_count;

  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    stuck_count = 8'h00;
  end

  // A real host waits out clock stretching, so the model waits too
  task automatic raise_scl;
    int n;
    scl_low = 1'b0;
    for (n = 0; n < 2000 && scl_line !== 1'b1; n++) begin
      #1;
    end
    if (scl_line !== 1'b1) begin
      stuck_count = stuck_count + 8'h01;
    end
  endtask

  task automatic send_byte(input logic with_start, input logic [7:0] b);
    int i;
    if (with_start) begin
      #3;
      sda_low = 1'b1;
      #8;
      scl_low = 1'b1;
      #8;
    end
    for (i = 7; i >= 0; i--) begin
      sda_low = !b[i];
      #8;
      raise_scl();
      #16;
      scl_low = 1'b1;
      #8;
    end
    sda_low = 1'b0;
  endtask

  task automatic ack_bit(output logic a);
    sda_low = 1'b0;
    #8;
    raise_scl();
    #8;
    a = sda_line;
    #8;
    scl_low = 1'b1;
    #8;
  endtask

  // Long low phase gives the client time to change data before the clock rises
  task automatic recv_byte(input logic nack, output logic [7:0] b);
    int i;
    sda_low = 1'b0;
    for (i = 7; i >= 0; i--) begin
      #24;
      raise_scl();
      #4;
      b[i] = sda_line;
      #4;
      scl_low = 1'b1;
    end
    #4;
    sda_low = !nack;
    #20;
    raise_scl();
    #8;
    scl_low = 1'b1;
    #4;
    sda_low = 1'b0;
    #4;
  endtask

  task automatic stop;
    sda_low = 1'b1;
    #8;
    raise_scl();
    #8;
    sda_low = 1'b0;
    #16;
  endtask
endmodule

// ### twac_client_tb.sv
// Self-checking bench for the two-wire client: registers, address match, hold, interrupt
`timescale 1ns/1ps
`include "twac_defines.vh"

module twac_client_tb;
  logic        clock;
  logic        arst_n;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dat_i;
  wire  [31:0] dat_o;
  wire         ack;
  wire         scl_o;
  wire         scl_oe;
  wire         sda_o;
  wire         sda_oe;
  wire         irq;
  wire         host_scl_low;
  wire         host_sda_low;
  wire         scl_line;
  wire         sda_line;
  int          err_count;
  int          compares;
  logic [7:0]  tm [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h06, 8'h06, 8'h61, 8'h61, 8'h60};
  logic [7:0]  tr [10] = '{8'hA4, 8'hA6, 8'hA5, 8'h00, 8'h00, 8'hA2, 8'hAC, 8'h60, 8'hA4, 8'h60};
  logic [9:0]  te = 10'h1AD;

  // Pull-ups: a line is low while any party enables its driver
  assign scl_line = !host_scl_low && (scl_oe ? scl_o : 1'b1);
  assign sda_line = !host_sda_low && (sda_oe ? sda_o : 1'b1);

  twac_client twac_client_inst (
    .CLOCK(clock), .ARST_N(arst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(sel), .WB_DAT_I(dat_i), .WB_DAT_O(dat_o), .WB_ACK_O(ack), .SCL_I(scl_line),
    .SCL_O(scl_o), .SCL_OE(scl_oe), .SDA_I(sda_line), .SDA_O(sda_o), .SDA_OE(sda_oe), .IRQ(irq));

  twac_i2c_host twac_i2c_host_inst (
    .scl_line(scl_line), .sda_line(sda_line), .scl_low(host_scl_low), .sda_low(host_sda_low));

  // ***********************************
  // Shared tasks
  // ***********************************
  task automatic conclude;
    if (err_count == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check_val(input string name, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wb(input logic wr, input logic [5:0] idx, input logic [7:0] wd, output logic [7:0] rd);
    int n;
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    adr <= {idx, 2'h0};
    dat_i <= {24'h000000, wd};
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rd = dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      err_count++;
      conclude();
    end
  endtask

  task automatic wait_hold;
    int n;
    for (n = 0; n < 40 && scl_oe !== 1'b1; n++) begin
      @(posedge clock);
    end
    #1;
  endtask

  // ***********************************
  // Scenarios
  // ***********************************
  task automatic s_reset_values;
    logic [7:0] d;
    wb(1'b0, `TWAC_IDX_ADDR, 8'h00, d);
    check_val("client_address", 8'h00, d);
    wb(1'b0, `TWAC_IDX_MASK, 8'h00, d);
    check_val("client_address_mask", 8'h00, d);
    wb(1'b0, `TWAC_IDX_DATA, 8'h00, d);
    check_val("client_data", 8'h00, d);
    wb(1'b1, 6'h3F, 8'hFF, d);
    wb(1'b0, 6'h3F, 8'h00, d);
    check_val("unmapped", 8'h00, d);
    wb(1'b1, `TWAC_IDX_MASK, 8'h5B, d);
    wb(1'b0, `TWAC_IDX_MASK, 8'h00, d);
    check_val("mask_readback", 8'h5B, d);
  endtask

  // Smart read answers the address, then, when the address was ACKed, a host write byte, then stop
  task automatic s_smart(input logic nack);
    logic [7:0] d;
    logic       a;
    wb(1'b1, `TWAC_IDX_IRQ_MASK, nack ? 8'h00 : 8'h07, d);
    wb(1'b1, `TWAC_IDX_MASK, 8'h00, d);
    wb(1'b1, `TWAC_IDX_ADDR, 8'hA4, d);
    wb(1'b1, `TWAC_IDX_CTRL, {6'h00, nack, 1'b1}, d);
    twac_i2c_host_inst.send_byte(1'b1, 8'hA4);
    wait_hold();
    check_val("hold_irq", {6'h00, 1'b1, !nack}, {6'h00, scl_oe, irq});
    wb(1'b0, `TWAC_IDX_STATUS, 8'h00, d);
    check_val("status_address", 8'h61, d);
    wb(1'b0, `TWAC_IDX_IRQ_STAT, 8'h00, d);
    check_val("irq_status", 8'h01, d);
    wb(1'b0, `TWAC_IDX_DATA, 8'h00, d);
    #1;
    check_val("release", {6'h00, 1'b0, !nack}, {6'h00, scl_oe, sda_oe});
    twac_i2c_host_inst.ack_bit(a);
    check_val("host_ack", {7'h00, nack}, {7'h00, a});
    if (!nack) begin
      twac_i2c_host_inst.send_byte(1'b0, 8'h3C);
      wait_hold();
      wb(1'b0, `TWAC_IDX_STATUS, 8'h00, d);
      check_val("status_data", 8'hA0, d & 8'hE0);
      wb(1'b0, `TWAC_IDX_DATA, 8'h00, d);
      check_val("rx_data", 8'h3C, d);
      wb(1'b0, `TWAC_IDX_STATUS, 8'h00, d);
      check_val("dif_cleared", 8'h00, d & 8'hA0);
      twac_i2c_host_inst.ack_bit(a);
      check_val("data_ack", 8'h00, {7'h00, a});
    end
    twac_i2c_host_inst.stop();
    repeat (8) @(posedge clock);
    // Status first: any data access clears the address-or-stop flag too
    wb(1'b0, `TWAC_IDX_STATUS, 8'h00, d);
    check_val("status_stop", 8'h40, d & 8'h41);
    wb(1'b0, `TWAC_IDX_DATA, 8'h00, d);
    check_val("data_idle", 8'h00, d);
    wb(1'b0, `TWAC_IDX_IRQ_STAT, 8'h00, d);
    check_val("irq_stop_data", nack ? 8'h02 : 8'h06, d);
  endtask

  // Address filter table: primary, direction bit, general call, mask, second address
  task automatic s_filter;
    logic [7:0] d;
    logic       a;
    int         i;
    for (i = 0; i < 10; i++) begin
      wb(1'b1, `TWAC_IDX_ADDR, (i == 3) ? 8'hA5 : 8'hA4, d);
      wb(1'b1, `TWAC_IDX_MASK, tm[i], d);
      twac_i2c_host_inst.send_byte(1'b1, tr[i]);
      wait_hold();
      check_val("address_match", {7'h00, te[i]}, {7'h00, scl_oe});
      if (te[i]) wb(1'b1, `TWAC_IDX_CTRL, 8'h0A, d);
      twac_i2c_host_inst.ack_bit(a);
      check_val("nack_seen", 8'h01, {7'h00, a});
      twac_i2c_host_inst.stop();
      wb(1'b0, `TWAC_IDX_IRQ_STAT, 8'h00, d);
    end
  endtask

  // Host read: response command, one byte out, host NACK, then complete
  task automatic s_host_read;
    logic [7:0] d;
    logic       a;
    wb(1'b1, `TWAC_IDX_IRQ_MASK, 8'h07, d);
    wb(1'b1, `TWAC_IDX_MASK, 8'h00, d);
    wb(1'b1, `TWAC_IDX_ADDR, 8'hA4, d);
    twac_i2c_host_inst.send_byte(1'b1, 8'hA5);
    wait_hold();
    wb(1'b0, `TWAC_IDX_STATUS, 8'h00, d);
    check_val("status_read_addr", 8'h63, d);
    wb(1'b1, `TWAC_IDX_CTRL, 8'h0C, d);
    twac_i2c_host_inst.ack_bit(a);
    check_val("read_addr_ack", 8'h00, {7'h00, a});
    wait_hold();
    wb(1'b1, `TWAC_IDX_DATA, 8'h5A, d);
    twac_i2c_host_inst.recv_byte(1'b1, d);
    check_val("tx_data", 8'h5A, d);
    wait_hold();
    wb(1'b0, `TWAC_IDX_STATUS, 8'h00, d);
    check_val("status_tx_done", 8'hB3, d);
    wb(1'b1, `TWAC_IDX_CTRL, 8'h08, d);
    twac_i2c_host_inst.stop();
    wb(1'b0, `TWAC_IDX_IRQ_STAT, 8'h00, d);
    check_val("irq_read_path", 8'h07, d);
  endtask

  // ***********************************
  // Clock, reset and sequence
  // ***********************************
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  initial begin
    #400000;
    err_count++;
    conclude();
  end

  initial begin
    arst_n = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'hF;
    dat_i = 32'h00000000;
    err_count = 0;
    compares = 0;
    repeat (3) @(posedge clock);
    arst_n <= 1'b1;
    repeat (4) @(posedge clock);
    s_reset_values();
    s_smart(1'b0);
    s_smart(1'b1);
    s_filter();
    s_host_read();
    check_val("host_stalls", 8'h00, twac_i2c_host_inst.stuck_count);
    conclude();
  end
endmodule
